/* File: verilog/adcseq_consts.svh */
// Offsets, field positions, reset values and timing counts of the conversion sequencer.
`ifndef ADCSEQ_CONSTS_SVH
`define ADCSEQ_CONSTS_SVH

// =====================================================================
// Register indices (byte address is four times the index)
`define ADCSEQ_IDX_INT_CTRL 10'h00b
`define ADCSEQ_IDX_IRQ_FLAGS 10'h00c
`define ADCSEQ_IDX_RESULT 10'h01e
`define ADCSEQ_IDX_CTRL_MAIN 10'h01f
`define ADCSEQ_IDX_IRQ_ENABLES 10'h08c
`define ADCSEQ_IDX_PIN_CFG 10'h09f
`define ADCSEQ_IDX_INVALID 10'h0a0

// =====================================================================
// Field positions
`define ADCSEQ_CTRL_SEL_HI 7
`define ADCSEQ_CTRL_SEL_LO 6
`define ADCSEQ_CTRL_CHAN_HI 5
`define ADCSEQ_CTRL_CHAN_LO 3
`define ADCSEQ_CTRL_GO 2
`define ADCSEQ_CTRL_ON 0
`define ADCSEQ_DONE_BIT 6
`define ADCSEQ_PIN_CFG_HI 2

// =====================================================================
// Reset values
`define ADCSEQ_RST_BYTE 8'h00
`define ADCSEQ_RST_SEL 2'h0
`define ADCSEQ_RST_CHAN 3'h0
`define ADCSEQ_RST_PIN_CFG 3'h0

// =====================================================================
// Encodings
`define ADCSEQ_SEL_RC 2'h3
`define ADCSEQ_TRIG_MODE 4'hb

// =====================================================================
// Timing
`define ADCSEQ_CLK_NS 4
`define ADCSEQ_MIN_TAD_NS 1600
`define ADCSEQ_MIN_TAD_NS_ALT 2000
`define ADCSEQ_INSTR_TOSC 4
`define ADCSEQ_LEAD_HALF 3
`define ADCSEQ_RECOVER_HALF 4
`define ADCSEQ_CONV_HALF 19

`endif

/* File: verilog/adcseq_pkg.sv */
// Types and shared arithmetic of the conversion sequencer.
`default_nettype none
package adcseq_pkg;

  // =====================================================================
  // Sequencer states, Gray coded along idle, wait, lead, convert, recover.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT = 3'b001,
    ST_LEAD = 3'b011,
    ST_CONV = 3'b010,
    ST_RECOVER = 3'b110
  } adcseq_state_type;

  // Oscillator periods per bit period for a clock selection; zero means the RC clock.
  function automatic int tosc_mult(input logic [1:0] sel);
    case (sel)
      2'h0: return 2;
      2'h1: return 8;
      2'h2: return 32;
      default: return 0;
    endcase
  endfunction

endpackage
`default_nettype wire

/* File: verilog/adcseq_sar_if.sv */
// Signals between the sequencer control and the successive approximation engine.
`timescale 1ns/1ps
`default_nettype none
interface adcseq_sar_if;
  logic clear;
  logic step;
  logic comp;
  logic done;
  logic [7:0] code;
  logic [2:0] bit_idx;
  modport ctrl (output clear, output step, output comp, input done, input code, input bit_idx);
  modport engine (input clear, input step, input comp, output done, output code, output bit_idx);
endinterface
`default_nettype wire

/* File: verilog/adcseq_tad_gen.sv */
// Half bit-period tick generator from the divided oscillator or the internal RC clock.
`timescale 1ns/1ps
`default_nettype none
module adcseq_tad_gen #(
  parameter int OSC_DIV = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic run,
  input wire logic use_rc,
  input wire logic [1:0] sel,
  input wire logic rc_clk,
  output logic half_tick
);

  logic rc_s1_q;
  logic rc_s2_q;
  logic rc_s3_q;
  logic [15:0] cnt_q;
  logic [15:0] reload;

  // A new selection is picked up at the next half period, so a switch lands cleanly.
  assign reload = 16'(adcseq_pkg::tosc_mult(sel) / 2 * OSC_DIV - 1);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rc_s1_q <= 1'b0;
      rc_s2_q <= 1'b0;
      rc_s3_q <= 1'b0;
    end else begin
      rc_s1_q <= rc_clk;
      rc_s2_q <= rc_s1_q;
      rc_s3_q <= rc_s2_q;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
      half_tick <= 1'b0;
    end else if (!run) begin
      cnt_q <= reload;
      half_tick <= 1'b0;
    end else if (use_rc) begin
      half_tick <= rc_s2_q ^ rc_s3_q;
    end else if (cnt_q == 16'h0000) begin
      cnt_q <= reload;
      half_tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q - 16'h0001;
      half_tick <= 1'b0;
    end
  end

endmodule // adcseq_tad_gen
`default_nettype wire

/* File: verilog/adcseq_sar.sv */
// Successive approximation engine: trial code, bit walk and end of conversion.
`timescale 1ns/1ps
`default_nettype none
module adcseq_sar (
  input wire logic clock,
  input wire logic rst_n,
  adcseq_sar_if.engine sar
);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sar.code <= 8'h00;
      sar.bit_idx <= 3'h7;
      sar.done <= 1'b0;
    end else if (sar.clear) begin
      sar.code <= 8'h80;
      sar.bit_idx <= 3'h7;
      sar.done <= 1'b0;
    end else if (sar.step && !sar.done) begin
      // Trial code k stands for k times the reference over 256, so code 1 begins at one LSb.
      sar.code[sar.bit_idx] <= sar.comp;
      if (sar.bit_idx == 3'h0) begin
        sar.done <= 1'b1;
      end else begin
        sar.code[sar.bit_idx - 3'h1] <= 1'b1;
        sar.bit_idx <= sar.bit_idx - 3'h1;
      end
    end else begin
      sar.done <= 1'b0;
    end
  end

endmodule // adcseq_sar
`default_nettype wire

/* File: verilog/adcseq_top.sv */
// Conversion sequencer of an 8-bit successive approximation converter with APB registers.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "adcseq_consts.svh"
module adcseq_top #(
  parameter int ADDR_W = 12,
  parameter int OSC_DIV = 1,
  parameter int MIN_TAD_NS = `ADCSEQ_MIN_TAD_NS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_in,
  input wire logic [3:0] compare_unit_mode,
  input wire logic special_event_trigger,
  input wire logic rc_osc_clk,
  input wire logic comparator_in,
  output logic converter_power,
  output logic sample_enable,
  output logic [2:0] channel_select,
  output logic [2:0] analog_pin_config_bits,
  output logic [7:0] dac_code,
  output logic wake_request,
  output logic timer_clear
);

  localparam int MIN_TAD_CYC = (MIN_TAD_NS + `ADCSEQ_CLK_NS - 1) / `ADCSEQ_CLK_NS;
  localparam int INSTR_CYC = `ADCSEQ_INSTR_TOSC * OSC_DIV;

  // =====================================================================
  // Declarations
  adcseq_pkg::adcseq_state_type state_q;
  logic [1:0] clk_sel_q;
  logic [2:0] chan_q;
  logic busy_q;
  logic on_q;
  logic [7:0] int_ctrl_q;
  logic [7:0] irq_flags_q;
  logic [7:0] irq_enables_q;
  logic [2:0] pin_cfg_q;
  logic [7:0] result_q;
  logic [7:0] invalid_q;
  logic rc_q;
  logic [15:0] cnt_q;
  logic phase_q;
  logic pwr_down_q;
  logic comp_s1_q;
  logic comp_s2_q;
  logic [4:0] half_seen_q;
  logic [7:0] rd_byte;
  logic rd_err;
  logic half_tick;
  logic wr;
  logic wr_ctrl;
  logic running;
  logic start;
  logic sleep_kill;
  logic sw_go_set;
  logic sw_go_clr;
  logic off_kill;
  logic abort;
  logic complete;
  logic trig_hit;
  logic trig_go;

  adcseq_sar_if sar_bus ();

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
    return a == ADDR_W'({idx, 2'b00});
  endfunction

  // =====================================================================
  // Sub-blocks
  adcseq_tad_gen #(
    .OSC_DIV(OSC_DIV)
  ) u_tad (
    .clock(clock),
    .rst_n(rst_n),
    .run(state_q != adcseq_pkg::ST_IDLE),
    .use_rc(rc_q),
    .sel(clk_sel_q),
    .rc_clk(rc_osc_clk),
    .half_tick(half_tick)
  );

  adcseq_sar u_sar (
    .clock(clock),
    .rst_n(rst_n),
    .sar(sar_bus.engine)
  );

  // =====================================================================
  // Event decoding
  assign wr = psel && penable && pwrite && pready;
  assign wr_ctrl = wr && hit(paddr, `ADCSEQ_IDX_CTRL_MAIN);
  assign running = (state_q == adcseq_pkg::ST_WAIT) || (state_q == adcseq_pkg::ST_LEAD) ||
                   (state_q == adcseq_pkg::ST_CONV);
  assign sw_go_set = wr_ctrl && pwdata[`ADCSEQ_CTRL_GO] && on_q;
  assign sw_go_clr = wr_ctrl && !pwdata[`ADCSEQ_CTRL_GO] && busy_q;
  assign off_kill = wr_ctrl && !pwdata[`ADCSEQ_CTRL_ON] && busy_q;
  assign sleep_kill = sleep_in && busy_q &&
                      !(running ? rc_q : (clk_sel_q == `ADCSEQ_SEL_RC));
  assign abort = running && (sw_go_clr || off_kill || sleep_kill);
  assign complete = sar_bus.done && (state_q == adcseq_pkg::ST_CONV);
  assign trig_hit = special_event_trigger && (compare_unit_mode == `ADCSEQ_TRIG_MODE);
  assign trig_go = trig_hit && on_q;
  assign start = (state_q == adcseq_pkg::ST_IDLE) && busy_q && on_q && !sleep_kill;
  assign sar_bus.clear = start;
  assign sar_bus.step = (state_q == adcseq_pkg::ST_CONV) && half_tick && phase_q && !abort;
  assign sar_bus.comp = comp_s2_q;

  // =====================================================================
  // Comparator synchroniser
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      comp_s1_q <= 1'b0;
      comp_s2_q <= 1'b0;
    end else begin
      comp_s1_q <= comparator_in;
      comp_s2_q <= comp_s1_q;
    end
  end

  // =====================================================================
  // Control register and busy bit
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clk_sel_q <= `ADCSEQ_RST_SEL;
      chan_q <= `ADCSEQ_RST_CHAN;
      on_q <= 1'b0;
    end else if (wr_ctrl) begin
      clk_sel_q <= pwdata[`ADCSEQ_CTRL_SEL_HI:`ADCSEQ_CTRL_SEL_LO];
      chan_q <= pwdata[`ADCSEQ_CTRL_CHAN_HI:`ADCSEQ_CTRL_CHAN_LO];
      on_q <= pwdata[`ADCSEQ_CTRL_ON];
    end
  end

  // A start request wins over a completion in the same cycle, so it is not lost.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else if (sw_go_set || trig_go) begin
      busy_q <= 1'b1;
    end else if (complete || sw_go_clr || off_kill || sleep_kill) begin
      busy_q <= 1'b0;
    end
  end

  // =====================================================================
  // Sequencer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= adcseq_pkg::ST_IDLE;
      rc_q <= 1'b0;
      cnt_q <= 16'h0000;
      phase_q <= 1'b0;
    end else begin
      case (state_q)
        adcseq_pkg::ST_IDLE: begin
          if (start) begin
            // The clock kind is frozen for the whole conversion.
            rc_q <= (clk_sel_q == `ADCSEQ_SEL_RC);
            if (clk_sel_q == `ADCSEQ_SEL_RC) begin
              state_q <= adcseq_pkg::ST_WAIT;
              cnt_q <= 16'(INSTR_CYC - 1);
            end else begin
              state_q <= adcseq_pkg::ST_LEAD;
              cnt_q <= 16'(`ADCSEQ_LEAD_HALF - 1);
            end
          end
        end
        adcseq_pkg::ST_WAIT: begin
          if (abort) begin
            state_q <= adcseq_pkg::ST_RECOVER;
            cnt_q <= 16'(`ADCSEQ_RECOVER_HALF - 1);
          end else if (cnt_q == 16'h0000) begin
            state_q <= adcseq_pkg::ST_LEAD;
            cnt_q <= 16'(`ADCSEQ_LEAD_HALF - 1);
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        adcseq_pkg::ST_LEAD: begin
          if (abort) begin
            state_q <= adcseq_pkg::ST_RECOVER;
            cnt_q <= 16'(`ADCSEQ_RECOVER_HALF - 1);
          end else if (half_tick) begin
            if (cnt_q == 16'h0000) begin
              state_q <= adcseq_pkg::ST_CONV;
              phase_q <= 1'b0;
            end else begin
              cnt_q <= cnt_q - 16'h0001;
            end
          end
        end
        adcseq_pkg::ST_CONV: begin
          if (abort || complete) begin
            state_q <= adcseq_pkg::ST_RECOVER;
            cnt_q <= 16'(`ADCSEQ_RECOVER_HALF - 1);
          end else if (half_tick) begin
            phase_q <= !phase_q;
          end
        end
        adcseq_pkg::ST_RECOVER: begin
          if (half_tick) begin
            if (cnt_q == 16'h0000) begin
              state_q <= adcseq_pkg::ST_IDLE;
            end else begin
              cnt_q <= cnt_q - 16'h0001;
            end
          end
        end
        default: begin
          state_q <= adcseq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // =====================================================================
  // Result, invalid-bit mask and flags
  // The result has no reset, so it keeps the last value through any reset.
  always_ff @(posedge clock) begin
    if (complete) begin
      result_q <= sar_bus.code;
    end else if (wr && hit(paddr, `ADCSEQ_IDX_RESULT)) begin
      result_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      invalid_q <= `ADCSEQ_RST_BYTE;
    end else if (start) begin
      invalid_q <= `ADCSEQ_RST_BYTE;
    end else if (sar_bus.step && !rc_q &&
                 (adcseq_pkg::tosc_mult(clk_sel_q) * OSC_DIV < MIN_TAD_CYC)) begin
      invalid_q[sar_bus.bit_idx] <= 1'b1;
    end
  end

  // The done flag is set by completion even when software clears it in the same cycle.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_flags_q <= `ADCSEQ_RST_BYTE;
    end else begin
      if (wr && hit(paddr, `ADCSEQ_IDX_IRQ_FLAGS)) begin
        irq_flags_q <= pwdata[7:0];
      end
      if (complete) begin
        irq_flags_q[`ADCSEQ_DONE_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      int_ctrl_q <= `ADCSEQ_RST_BYTE;
      irq_enables_q <= `ADCSEQ_RST_BYTE;
      pin_cfg_q <= `ADCSEQ_RST_PIN_CFG;
    end else begin
      if (wr && hit(paddr, `ADCSEQ_IDX_INT_CTRL)) begin
        int_ctrl_q <= pwdata[7:0];
      end
      if (wr && hit(paddr, `ADCSEQ_IDX_IRQ_ENABLES)) begin
        irq_enables_q <= pwdata[7:0];
      end
      if (wr && hit(paddr, `ADCSEQ_IDX_PIN_CFG)) begin
        pin_cfg_q <= pwdata[`ADCSEQ_PIN_CFG_HI:0];
      end
    end
  end

  // =====================================================================
  // Sleep, power and outputs toward the chip
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pwr_down_q <= 1'b1;
    end else if (sleep_in && (clk_sel_q != `ADCSEQ_SEL_RC || running && !rc_q)) begin
      pwr_down_q <= 1'b1;
    end else if (complete && sleep_in && !irq_enables_q[`ADCSEQ_DONE_BIT]) begin
      pwr_down_q <= 1'b1;
    end else if (!sleep_in) begin
      pwr_down_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      converter_power <= 1'b0;
      sample_enable <= 1'b0;
      wake_request <= 1'b0;
      timer_clear <= 1'b0;
    end else begin
      converter_power <= on_q && !pwr_down_q;
      // Sampling runs while the sequencer rests in idle with the converter on and not powered down.
      sample_enable <= on_q && !pwr_down_q && (state_q == adcseq_pkg::ST_IDLE);
      wake_request <= complete && sleep_in && irq_enables_q[`ADCSEQ_DONE_BIT];
      timer_clear <= trig_hit;
    end
  end

  assign channel_select = chan_q;
  assign analog_pin_config_bits = pin_cfg_q;
  assign dac_code = sar_bus.code;

  // =====================================================================
  // APB slave: data is fetched in the setup cycle and answered in one access cycle
  always_comb begin
    rd_byte = 8'h00;
    rd_err = 1'b0;
    if (hit(paddr, `ADCSEQ_IDX_INT_CTRL)) begin
      rd_byte = int_ctrl_q;
    end else if (hit(paddr, `ADCSEQ_IDX_IRQ_FLAGS)) begin
      rd_byte = irq_flags_q;
    end else if (hit(paddr, `ADCSEQ_IDX_RESULT)) begin
      rd_byte = result_q;
    end else if (hit(paddr, `ADCSEQ_IDX_CTRL_MAIN)) begin
      rd_byte = {clk_sel_q, chan_q, busy_q, 1'b0, on_q};
    end else if (hit(paddr, `ADCSEQ_IDX_IRQ_ENABLES)) begin
      rd_byte = irq_enables_q;
    end else if (hit(paddr, `ADCSEQ_IDX_PIN_CFG)) begin
      rd_byte = {5'h00, pin_cfg_q};
    end else if (hit(paddr, `ADCSEQ_IDX_INVALID)) begin
      rd_byte = invalid_q;
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && rd_err;
      prdata <= (psel && !penable && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // =====================================================================
  // Checks
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      half_seen_q <= 5'h00;
    end else if (start) begin
      half_seen_q <= 5'h00;
    end else if (half_tick && (state_q == adcseq_pkg::ST_LEAD ||
                               state_q == adcseq_pkg::ST_CONV)) begin
      half_seen_q <= half_seen_q + 5'h01;
    end
  end

  conv_length_a: assert property (@(posedge clock) disable iff (!rst_n)
    complete |-> half_seen_q == 5'(`ADCSEQ_CONV_HALF))
    else $error("conversion length is not 9.5 bit periods");

  done_update_a: assert property (@(posedge clock) disable iff (!rst_n)
    complete && !sw_go_set && !trig_go |=> !busy_q && result_q == $past(sar_bus.code))
    else $error("completion did not clear busy and load result");

  rc_delay_a: assert property (@(posedge clock) disable iff (!rst_n)
    start && clk_sel_q == `ADCSEQ_SEL_RC |=> (state_q == adcseq_pkg::ST_WAIT) [*2])
    else $error("RC start was not delayed");

  sleep_abort_a: assert property (@(posedge clock) disable iff (!rst_n)
    running && sleep_in && !rc_q && !wr_ctrl
      |=> state_q == adcseq_pkg::ST_RECOVER && pwr_down_q && on_q && !busy_q)
    else $error("sleep with oscillator clock did not abort");

  sleep_run_a: assert property (@(posedge clock) disable iff (!rst_n)
    sleep_in && $past(sleep_in) && running |-> rc_q)
    else $error("conversion runs in sleep without RC clock");

  wake_a: assert property (@(posedge clock) disable iff (!rst_n)
    complete && sleep_in && irq_enables_q[`ADCSEQ_DONE_BIT] |=> wake_request ##1 !wake_request)
    else $error("no single wake pulse on completion in sleep");

  power_down_a: assert property (@(posedge clock) disable iff (!rst_n)
    complete && sleep_in && !irq_enables_q[`ADCSEQ_DONE_BIT] && !wr_ctrl
      |=> pwr_down_q && on_q ##1 !converter_power)
    else $error("converter not powered down after sleep completion");

  trig_start_a: assert property (@(posedge clock) disable iff (!rst_n)
    trig_hit && on_q && !wr_ctrl |=> busy_q && timer_clear)
    else $error("trigger did not start conversion and clear timer");

  trig_ignore_a: assert property (@(posedge clock) disable iff (!rst_n)
    trig_hit && !on_q && !busy_q && !wr_ctrl |=> !busy_q && timer_clear)
    else $error("trigger with converter off misbehaved");

  abort_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
    running && sw_go_clr && !complete
      |=> state_q == adcseq_pkg::ST_RECOVER && $stable(result_q))
    else $error("abort did not keep the result");

  invalid_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
    sar_bus.step && !rc_q && adcseq_pkg::tosc_mult(clk_sel_q) * OSC_DIV < MIN_TAD_CYC
      |=> invalid_q[$past(sar_bus.bit_idx)])
    else $error("short bit period not flagged");

endmodule // adcseq_top
`default_nettype wire

/* File: sim/adcseq_far_model.sv */
// Model of the analog input and the internal RC oscillator facing the sequencer.
`timescale 1ns/1ps
`default_nettype none
module adcseq_far_model (
  input wire logic [7:0] dac_code,
  input wire logic [7:0] vin,
  input wire logic rc_run,
  output logic comparator_in,
  output logic rc_osc_clk
);
  // The comparator trips once the input reaches the trial level, one step per code.
  assign comparator_in = (vin >= dac_code);
  // The RC clock stands still unless the bench lets it run.
  initial begin
    rc_osc_clk = 1'b0;
    forever begin
      #19;
      if (rc_run) rc_osc_clk = ~rc_osc_clk;
    end
  end
endmodule // adcseq_far_model
`default_nettype wire

/* File: sim/adcseq_tb_top.sv */
// Self-checking bench of the conversion sequencer.
`timescale 1ns/1ps
`default_nettype none
module adcseq_tb_top;
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, sleep_in, special_event_trigger;
  logic comparator_in, rc_osc_clk, rc_run, converter_power, sample_enable, wake_request;
  logic timer_clear, ev, hit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] compare_unit_mode;
  logic [2:0] channel_select, analog_pin_config_bits;
  logic [7:0] dac_code, vin;
  int err_total, cmp_count;
  adcseq_top u_dut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sleep_in, .compare_unit_mode, .special_event_trigger, .rc_osc_clk,
    .comparator_in, .converter_power, .sample_enable, .channel_select,
    .analog_pin_config_bits, .dac_code, .wake_request, .timer_clear);
  adcseq_far_model u_far (.dac_code, .vin, .rc_run, .comparator_in, .rc_osc_clk);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // ==========================================
  // Shared tasks
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bail(input logic ok);
    if (!ok) begin
      err_total++;
      wrap_up();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    bail(pready === 1'b1);
    rd = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, 12'h07c, 8'h00);
      n++;
    end while (rd[2] !== 1'b0 && n < 2000);
    bail(n < 2000);
  endtask
  task automatic look(input logic fire, input logic on_wake, input int lim);
    int n;
    n = 0;
    hit = 1'b0;
    special_event_trigger <= fire;
    @(posedge clock);
    special_event_trigger <= 1'b0;
    while (hit !== 1'b1 && n < lim) begin
      @(negedge clock);
      hit = on_wake ? wake_request : timer_clear;
      n++;
    end
    @(posedge clock);
  endtask
  // ==========================================
  // Scenarios
  task automatic s_regs();
    logic [11:0] adr [5] = '{12'h02c, 12'h030, 12'h07c, 12'h230, 12'h27c};
    foreach (adr[i]) begin
      apb(1'b0, adr[i], 8'h00);
      chk(rd, 32'h0000_0000);
    end
    apb(1'b1, 12'h27c, 8'h05);
    chk(analog_pin_config_bits, 32'h0000_0005);
    apb(1'b0, 12'h3fc, 8'h00);
    chk(ev, 32'h0000_0001);
    apb(1'b1, 12'h07c, 8'h28);
    chk(channel_select, 32'h0000_0005);
  endtask
  task automatic s_conv();
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, 12'h030, 8'h00);
      apb(1'b1, 12'h07c, {s[1:0], 6'h01});
      apb(1'b1, 12'h07c, {s[1:0], 6'h05});
      wait_idle();
      apb(1'b0, 12'h030, 8'h00);
      chk(rd, 32'h0000_0040);
      apb(1'b0, 12'h280, 8'h00);
      chk(rd, 32'h0000_00ff);
    end
    apb(1'b0, 12'h078, 8'h00);
    chk(rd, {24'h00_0000, vin});
    chk(dac_code, {24'h00_0000, vin});
  endtask
  task automatic s_trig();
    look(1'b1, 1'b0, 4);
    chk(hit, 32'h0000_0000);
    compare_unit_mode <= 4'hb;
    apb(1'b1, 12'h07c, 8'h80);
    look(1'b1, 1'b0, 4);
    chk(hit, 32'h0000_0001);
    apb(1'b0, 12'h07c, 8'h00);
    chk(rd, 32'h0000_0080);
    apb(1'b1, 12'h07c, 8'h81);
    look(1'b1, 1'b0, 4);
    chk(hit, 32'h0000_0001);
    apb(1'b0, 12'h07c, 8'h00);
    chk(rd[2], 32'h0000_0001);
    wait_idle();
  endtask
  task automatic s_abort();
    vin <= 8'h3c;
    apb(1'b1, 12'h07c, 8'h85);
    repeat (120) @(posedge clock);
    apb(1'b1, 12'h07c, 8'h81);
    apb(1'b0, 12'h078, 8'h00);
    chk(rd, 32'h0000_00a5);
    repeat (80) @(posedge clock);
    apb(1'b1, 12'h07c, 8'h85);
    sleep_in <= 1'b1;
    repeat (4) @(posedge clock);
    chk(converter_power, 32'h0000_0000);
    chk(sample_enable, 32'h0000_0000);
    sleep_in <= 1'b0;
    apb(1'b0, 12'h07c, 8'h00);
    chk(rd, 32'h0000_0081);
  endtask
  task automatic s_rc();
    rc_run <= 1'b1;
    repeat (80) @(posedge clock);
    for (int e = 1; e >= 0; e--) begin
      apb(1'b1, 12'h230, {1'b0, e[0], 6'h00});
      apb(1'b1, 12'h07c, 8'hc1);
      apb(1'b1, 12'h07c, 8'hc5);
      sleep_in <= 1'b1;
      look(1'b0, 1'b1, 3000);
      chk(hit, {31'h0000_0000, e[0]});
      chk(converter_power, {31'h0000_0000, e[0]});
      sleep_in <= 1'b0;
      apb(1'b0, 12'h07c, 8'h00);
      chk(rd, 32'h0000_00c1);
    end
    apb(1'b0, 12'h078, 8'h00);
    chk(rd, 32'h0000_003c);
    apb(1'b0, 12'h280, 8'h00);
    chk(rd, 32'h0000_0000);
    apb(1'b1, 12'h07c, 8'h85);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    chk(converter_power, 32'h0000_0000);
    rst_n <= 1'b1;
    rc_run <= 1'b0;
    @(posedge clock);
    apb(1'b0, 12'h07c, 8'h00);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 12'h078, 8'h00);
    chk(rd, 32'h0000_003c);
  endtask
  initial begin
    {rst_n, psel, penable, pwrite, sleep_in, special_event_trigger, rc_run} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    compare_unit_mode = 4'h0;
    vin = 8'ha5;
    err_total = 0;
    cmp_count = 0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    s_regs();
    s_conv();
    s_trig();
    s_abort();
    s_rc();
    wrap_up();
  end
endmodule // adcseq_tb_top
`default_nettype wire
